/* File: design/pst_pkg.sv */
package pst_pkg;

    // ----------------------------------------
    // Register offsets, bank 0
    // ----------------------------------------
    localparam logic [7:0] PST_OFS_TBL_HIGH  = 8'h82;
    localparam logic [7:0] PST_OFS_LOC       = 8'h83;
    localparam logic [7:0] PST_OFS_BANK      = 8'h84;
    localparam logic [7:0] PST_OFS_STK_PTR   = 8'hdf;
    localparam logic [7:0] PST_OFS_STK_FIRST = 8'hf0;
    localparam logic [7:0] PST_OFS_STK_LAST  = 8'hf7;
    localparam logic [7:0] PST_IMM_LO        = 8'h80;
    localparam logic [7:0] PST_IMM_HI        = 8'h87;
    localparam logic [7:0] PST_BANK0         = 8'h00;

    // ----------------------------------------
    // Field positions and widths
    // ----------------------------------------
    localparam int PST_GIE_BIT  = 7;
    localparam int PST_PC_W     = 10;
    localparam int PST_STK_LVLS = 4;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [1:0]  PST_STK_PTR_RST = 2'h3;
    localparam logic        PST_GIE_RST     = 1'b0;
    localparam logic [9:0]  PST_PC_RST      = 10'h000;
    localparam logic [7:0]  PST_WREG_RST    = 8'h00;
    localparam logic [15:0] PST_ADDR_RST    = 16'h0000;

    // ----------------------------------------
    // Modes and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PST_MODE_IMM = 2'h0,
        PST_MODE_DIR = 2'h1,
        PST_MODE_IND = 2'h2
    } pst_mode_t;

    typedef enum logic [2:0] {
        PST_ST_IDLE   = 3'b001,
        PST_ST_RAM_RD = 3'b010,
        PST_ST_ROM_RD = 3'b100
    } pst_state_t;

endpackage

/* File: design/pst_stack_if.sv */
`timescale 1ns/1ps
interface pst_stack_if;
    logic       push;
    logic       pop;
    logic [9:0] push_pc;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [9:0] pop_pc;
    logic       pop_valid;
    logic       global_irq_enable;

    modport stack (
        input  push, pop, push_pc, wr_en, wr_addr, wr_data, rd_addr,
        output rd_data, pop_pc, pop_valid, global_irq_enable
    );
    modport core (
        output push, pop, push_pc, wr_en, wr_addr, wr_data, rd_addr,
        input  rd_data, pop_pc, pop_valid, global_irq_enable
    );
endinterface

/* File: design/pst_call_stack.sv */
`timescale 1ns/1ps
module pst_call_stack
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic     i_sys_clk,
    input  wire logic     i_rst,
    // Core side
    pst_stack_if.stack    sif
);

    typedef struct packed {
        logic [PST_STK_LVLS-1:0][PST_PC_W-1:0] entry;
        logic [1:0]                            ptr;
        logic                                  global_irq_enable;
        logic [PST_PC_W-1:0]                   pop_pc;
        logic                                  pop_valid;
    } pst_stk_state_t;

    pst_stk_state_t cur_ff;
    pst_stk_state_t nxt_st;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] pop_idx;
        logic [1:0] wr_idx;
        pop_idx          = ~(cur_ff.ptr + 2'h1);
        wr_idx           = sif.wr_addr[2:1];
        nxt_st           = cur_ff;
        nxt_st.pop_valid = 1'b0;
        // Hardware push/pop outrank a software write in the same cycle
        if (sif.push) begin
            nxt_st.entry[~cur_ff.ptr] = sif.push_pc;
            nxt_st.ptr                = cur_ff.ptr - 2'h1;
        end else if (sif.pop) begin
            nxt_st.ptr       = cur_ff.ptr + 2'h1;
            nxt_st.pop_pc    = cur_ff.entry[pop_idx];
            nxt_st.pop_valid = 1'b1;
        end else if (sif.wr_en) begin
            if (sif.wr_addr == PST_OFS_STK_PTR) begin
                nxt_st.global_irq_enable = sif.wr_data[PST_GIE_BIT];
                nxt_st.ptr = sif.wr_data[1:0];
            end else if (sif.wr_addr >= PST_OFS_STK_FIRST && sif.wr_addr <= PST_OFS_STK_LAST) begin
                if (sif.wr_addr[0]) begin
                    nxt_st.entry[wr_idx][9:8] = sif.wr_data[1:0];
                end else begin
                    nxt_st.entry[wr_idx][7:0] = sif.wr_data;
                end
            end
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        logic [1:0] rd_idx;
        rd_idx      = sif.rd_addr[2:1];
        sif.rd_data = 8'h00;
        if (sif.rd_addr == PST_OFS_STK_PTR) begin
            sif.rd_data = {cur_ff.global_irq_enable, 5'h00, cur_ff.ptr};
        end else if (sif.rd_addr >= PST_OFS_STK_FIRST && sif.rd_addr <= PST_OFS_STK_LAST) begin
            if (sif.rd_addr[0]) begin
                sif.rd_data = {6'h00, cur_ff.entry[rd_idx][9:8]};
            end else begin
                sif.rd_data = cur_ff.entry[rd_idx][7:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_ff.entry     <= '0;
            cur_ff.ptr       <= PST_STK_PTR_RST;
            cur_ff.global_irq_enable       <= PST_GIE_RST;
            cur_ff.pop_pc    <= PST_PC_RST;
            cur_ff.pop_valid <= 1'b0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign sif.pop_pc    = cur_ff.pop_pc;
    assign sif.pop_valid = cur_ff.pop_valid;
    assign sif.global_irq_enable       = cur_ff.global_irq_enable;

endmodule

/* File: design/pst_core_regs.sv */
`timescale 1ns/1ps
module pst_core_regs
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,

    // Move operation from the sequencer
    input  wire logic        i_mv_valid,
    input  wire logic [1:0]  i_mv_mode,
    input  wire logic        i_mv_to_acc,
    input  wire logic [7:0]  i_mv_addr,
    input  wire logic [7:0]  i_mv_literal,
    input  wire logic [7:0]  i_accumulator,

    // Table read
    input  wire logic        i_rom_table_read,
    input  wire logic [15:0] i_rom_data,
    input  wire logic        i_rom_valid,
    output logic      [15:0] o_rom_addr,
    output logic             o_rom_re,

    // Data RAM
    input  wire logic [7:0]  i_ram_rdata,
    output logic      [15:0] o_ram_addr,
    output logic      [7:0]  o_ram_wdata,
    output logic             o_ram_we,
    output logic             o_ram_re,

    // Accumulator load
    output logic      [7:0]  o_accumulator,
    output logic             o_acc_we,

    // Return stack
    input  wire logic        i_stk_push,
    input  wire logic        i_stk_pop,
    input  wire logic [9:0]  i_program_counter,
    output logic      [9:0]  o_pc_restore,
    output logic             o_pc_restore_valid,

    // Status
    output logic             o_global_irq_enable,
    output logic             o_busy
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        pst_state_t  state;
        logic [7:0]  tbl_high;
        logic [7:0]  loc;
        logic [7:0]  bank;
        logic [7:0]  acc_data;
        logic        acc_we;
        logic [15:0] ram_addr;
        logic [7:0]  ram_wdata;
        logic        ram_we;
        logic        ram_re;
        logic [15:0] rom_addr;
        logic        rom_re;
    } pst_core_state_t;

    pst_core_state_t cur_ff;
    pst_core_state_t nxt_st;

    pst_stack_if sif ();

    pst_call_stack u_stack (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .sif       (sif)
    );

    // ----------------------------------------
    // Operand decode
    // ----------------------------------------
    pst_mode_t   mode;
    logic        take_mv;
    logic        take_tr;
    logic [15:0] op_addr;
    logic        op_bank0;
    logic        op_is_wreg;
    logic        op_is_stack;
    logic        op_internal;
    logic        imm_in_range;
    logic        wr_allowed;
    logic [7:0]  wr_value;
    logic [7:0]  int_rd_value;

    assign mode    = pst_mode_t'(i_mv_mode);
    assign take_mv = i_mv_valid && (cur_ff.state == PST_ST_IDLE);
    // A move and a table read in one cycle: the move is taken, the table read is not
    assign take_tr = i_rom_table_read && !i_mv_valid && (cur_ff.state == PST_ST_IDLE);

    always_comb begin
        case (mode)
            PST_MODE_IND: op_addr = {cur_ff.bank, cur_ff.loc};
            default:      op_addr = {PST_BANK0, i_mv_addr};
        endcase
    end

    assign op_bank0     = (op_addr[15:8] == PST_BANK0);
    assign op_is_wreg   = (op_addr[7:0] == PST_OFS_TBL_HIGH) ||
                          (op_addr[7:0] == PST_OFS_LOC) ||
                          (op_addr[7:0] == PST_OFS_BANK);
    assign op_is_stack  = (op_addr[7:0] == PST_OFS_STK_PTR) ||
                          (op_addr[7:0] >= PST_OFS_STK_FIRST && op_addr[7:0] <= PST_OFS_STK_LAST);
    assign op_internal  = op_bank0 && (op_is_wreg || op_is_stack);
    assign imm_in_range = (i_mv_addr >= PST_IMM_LO) && (i_mv_addr <= PST_IMM_HI);

    // Immediate stores outside the working range are dropped silently
    assign wr_allowed = (mode == PST_MODE_IMM) ? imm_in_range : 1'b1;
    assign wr_value   = (mode == PST_MODE_IMM) ? i_mv_literal : i_accumulator;

    always_comb begin
        case (op_addr[7:0])
            PST_OFS_TBL_HIGH: int_rd_value = cur_ff.tbl_high;
            PST_OFS_LOC:      int_rd_value = cur_ff.loc;
            PST_OFS_BANK:     int_rd_value = cur_ff.bank;
            default:          int_rd_value = sif.rd_data;
        endcase
    end

    // ----------------------------------------
    // Stack connections
    // ----------------------------------------
    assign sif.push    = i_stk_push;
    assign sif.pop     = i_stk_pop;
    assign sif.push_pc = i_program_counter;
    assign sif.rd_addr = op_addr[7:0];
    assign sif.wr_addr = op_addr[7:0];
    assign sif.wr_data = wr_value;
    assign sif.wr_en   = take_mv && !i_mv_to_acc && wr_allowed && op_bank0 && op_is_stack;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st        = cur_ff;
        nxt_st.acc_we = 1'b0;
        nxt_st.ram_we = 1'b0;
        nxt_st.ram_re = 1'b0;
        nxt_st.rom_re = 1'b0;
        case (cur_ff.state)
            PST_ST_IDLE: begin
                if (take_mv) begin
                    if (i_mv_to_acc) begin
                        if (mode == PST_MODE_IMM) begin
                            nxt_st.acc_data = i_mv_literal;
                            nxt_st.acc_we   = 1'b1;
                        end else if (op_internal) begin
                            nxt_st.acc_data = int_rd_value;
                            nxt_st.acc_we   = 1'b1;
                        end else begin
                            // External RAM answers in the same cycle as the strobe; the data is sampled at its end
                            nxt_st.ram_addr = op_addr;
                            nxt_st.ram_re   = 1'b1;
                            nxt_st.state    = PST_ST_RAM_RD;
                        end
                    end else if (wr_allowed) begin
                        if (op_internal) begin
                            if (op_addr[7:0] == PST_OFS_TBL_HIGH) begin
                                nxt_st.tbl_high = wr_value;
                            end
                            if (op_addr[7:0] == PST_OFS_LOC) begin
                                nxt_st.loc = wr_value;
                            end
                            if (op_addr[7:0] == PST_OFS_BANK) begin
                                nxt_st.bank = wr_value;
                            end
                        end else begin
                            nxt_st.ram_addr  = op_addr;
                            nxt_st.ram_wdata = wr_value;
                            nxt_st.ram_we    = 1'b1;
                        end
                    end
                end else if (take_tr) begin
                    nxt_st.rom_addr = {cur_ff.bank, cur_ff.loc};
                    nxt_st.rom_re   = 1'b1;
                    nxt_st.state    = PST_ST_ROM_RD;
                end
            end
            PST_ST_RAM_RD: begin
                nxt_st.acc_data = i_ram_rdata;
                nxt_st.acc_we   = 1'b1;
                nxt_st.state    = PST_ST_IDLE;
            end
            PST_ST_ROM_RD: begin
                // Waits as long as program memory needs
                if (i_rom_valid) begin
                    nxt_st.tbl_high = i_rom_data[15:8];
                    nxt_st.acc_data = i_rom_data[7:0];
                    nxt_st.acc_we   = 1'b1;
                    nxt_st.state    = PST_ST_IDLE;
                end
            end
            default: begin
                nxt_st.state = PST_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Working registers have no defined reset value; zero is used
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_ff.state     <= PST_ST_IDLE;
            cur_ff.tbl_high  <= PST_WREG_RST;
            cur_ff.loc       <= PST_WREG_RST;
            cur_ff.bank      <= PST_WREG_RST;
            cur_ff.acc_data  <= PST_WREG_RST;
            cur_ff.acc_we    <= 1'b0;
            cur_ff.ram_addr  <= PST_ADDR_RST;
            cur_ff.ram_wdata <= PST_WREG_RST;
            cur_ff.ram_we    <= 1'b0;
            cur_ff.ram_re    <= 1'b0;
            cur_ff.rom_addr  <= PST_ADDR_RST;
            cur_ff.rom_re    <= 1'b0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rom_addr          = cur_ff.rom_addr;
    assign o_rom_re            = cur_ff.rom_re;
    assign o_ram_addr          = cur_ff.ram_addr;
    assign o_ram_wdata         = cur_ff.ram_wdata;
    assign o_ram_we            = cur_ff.ram_we;
    assign o_ram_re            = cur_ff.ram_re;
    assign o_accumulator       = cur_ff.acc_data;
    assign o_acc_we            = cur_ff.acc_we;
    assign o_pc_restore        = sif.pop_pc;
    assign o_pc_restore_valid  = sif.pop_valid;
    assign o_global_irq_enable = sif.global_irq_enable;
    assign o_busy              = (cur_ff.state != PST_ST_IDLE);

endmodule

/* File: tb/pst_core_regs_assertions.sv */
`timescale 1ns/1ps
module pst_core_regs_chk
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Requests
    input  wire logic        i_mv_valid,
    input  wire logic [1:0]  i_mv_mode,
    input  wire logic        i_mv_to_acc,
    input  wire logic [7:0]  i_mv_addr,
    input  wire logic [7:0]  i_mv_literal,
    input  wire logic [7:0]  i_accumulator,
    input  wire logic        i_rom_table_read,
    input  wire logic [15:0] i_rom_data,
    input  wire logic        i_rom_valid,
    input  wire logic [7:0]  i_ram_rdata,
    input  wire logic        i_stk_push,
    input  wire logic        i_stk_pop,
    input  wire logic [9:0]  i_program_counter,
    // Responses
    input  wire logic        o_rom_re,
    input  wire logic [15:0] o_ram_addr,
    input  wire logic [7:0]  o_ram_wdata,
    input  wire logic        o_ram_we,
    input  wire logic        o_ram_re,
    input  wire logic [7:0]  o_accumulator,
    input  wire logic        o_acc_we,
    input  wire logic [9:0]  o_pc_restore,
    input  wire logic        o_pc_restore_valid,
    input  wire logic        o_global_irq_enable,
    input  wire logic        o_busy
);
    logic       mv_take;
    logic       ext_loc;
    logic [7:0] rom_lo_q;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Unmapped 0xf8 left out too, its routing is not pinned down
    assign mv_take = i_mv_valid && !o_busy;
    assign ext_loc = !(i_mv_addr inside {[PST_OFS_TBL_HIGH:PST_OFS_BANK], PST_OFS_STK_PTR, [PST_OFS_STK_FIRST:8'hf8]});
    always_ff @(posedge i_sys_clk) begin
        rom_lo_q <= i_rom_data[7:0];
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_push;
        i_stk_push && !i_stk_pop;
    endsequence
    sequence s_pop;
        i_stk_pop && !i_stk_push;
    endsequence

    property p_imm_acc;
        mv_take && i_mv_mode == PST_MODE_IMM && i_mv_to_acc |=> o_acc_we && o_accumulator == $past(i_mv_literal);
    endproperty
    property p_imm_range;
        mv_take && i_mv_mode == PST_MODE_IMM && !i_mv_to_acc && !(i_mv_addr inside {[PST_IMM_LO:PST_IMM_HI]})
            |=> !o_ram_we && !o_acc_we;
    endproperty
    property p_dir_store;
        mv_take && i_mv_mode == PST_MODE_DIR && !i_mv_to_acc && ext_loc
            |=> o_ram_we && o_ram_addr == {PST_BANK0, $past(i_mv_addr)} && o_ram_wdata == $past(i_accumulator);
    endproperty
    property p_ram_rd;
        o_ram_re |-> o_busy ##1 (o_acc_we && !o_busy && o_accumulator == $past(i_ram_rdata));
    endproperty
    property p_rom_req;
        i_rom_table_read && !i_mv_valid && !o_busy |=> o_rom_re && o_busy;
    endproperty
    property p_rom_ans;
        o_busy && !o_ram_re && i_rom_valid |=> o_acc_we && !o_busy && o_accumulator == rom_lo_q;
    endproperty
    property p_pop;
        s_pop |=> o_pc_restore_valid;
    endproperty
    property p_push_pop;
        s_push ##1 s_pop |=> o_pc_restore_valid && o_pc_restore == $past(i_program_counter, 2);
    endproperty
    property p_rst;
        !i_rst && $past(i_rst) |-> !o_global_irq_enable && !o_busy && !o_acc_we;
    endproperty

    a_imm_acc: assert property (p_imm_acc) else $error("immediate load missed");
    a_imm_range: assert property (p_imm_range) else $error("immediate store outside range acted");
    a_dir_store: assert property (p_dir_store) else $error("direct store wrong");
    a_ram_rd: assert property (p_ram_rd) else $error("ram read not returned");
    a_rom_req: assert property (p_rom_req) else $error("table read not issued");
    a_rom_ans: assert property (p_rom_ans) else $error("table low byte wrong");
    a_pop: assert property (p_pop) else $error("pop gave no restore");
    a_push_pop: assert property (p_push_pop) else $error("pop did not return last push");
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind pst_core_regs pst_core_regs_chk u_pst_core_regs_chk (
    .i_sys_clk, .i_rst, .i_mv_valid, .i_mv_mode, .i_mv_to_acc, .i_mv_addr, .i_mv_literal, .i_accumulator,
    .i_rom_table_read, .i_rom_data, .i_rom_valid, .i_ram_rdata, .i_stk_push, .i_stk_pop, .i_program_counter,
    .o_rom_re, .o_ram_addr, .o_ram_wdata, .o_ram_we, .o_ram_re, .o_accumulator, .o_acc_we,
    .o_pc_restore, .o_pc_restore_valid, .o_global_irq_enable, .o_busy
);

/* File: tb/pst_mem_model.sv */
`timescale 1ns/1ps
module pst_mem_model (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Requests from the block
    input  wire logic [15:0] i_ram_addr,
    input  wire logic        i_ram_re,
    input  wire logic [15:0] i_rom_addr,
    input  wire logic        i_rom_re,
    input  wire logic [1:0]  i_delay,
    // Answers
    output logic      [7:0]  o_ram_rdata,
    output logic      [15:0] o_rom_data,
    output logic             o_rom_valid
);
    logic [1:0] wait_ff;
    logic       pend_ff;
    logic [7:0] churn_ff;

    function automatic logic [7:0] ram_fn(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h3c;
    endfunction
    function automatic logic [15:0] rom_fn(input logic [15:0] a);
        return {a[7:0] ^ 8'ha5, a[15:8] + a[7:0]};
    endfunction

    // Lines churn outside a read so a mistimed sample is caught
    assign o_ram_rdata = i_ram_re ? ram_fn(i_ram_addr) : churn_ff;
    assign o_rom_data  = o_rom_valid ? rom_fn(i_rom_addr) : {churn_ff, ~churn_ff};

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_ff     <= 2'h0;
            pend_ff     <= 1'b0;
            churn_ff    <= 8'h00;
            o_rom_valid <= 1'b0;
        end else begin
            churn_ff    <= churn_ff + 8'h1d;
            o_rom_valid <= 1'b0;
            if (i_rom_re) begin
                pend_ff <= 1'b1;
                wait_ff <= i_delay;
            end else if (pend_ff && wait_ff == 2'h0) begin
                pend_ff     <= 1'b0;
                o_rom_valid <= 1'b1;
            end else if (pend_ff) begin
                wait_ff <= wait_ff - 2'h1;
            end
        end
    end
endmodule

/* File: tb/pointer_regs_and_call_stack_tb_top.sv */
`timescale 1ns/1ps
module pointer_regs_and_call_stack_tb_top
    import pst_pkg::*;
;
    logic        i_sys_clk, i_rst, i_mv_valid, i_mv_to_acc, i_rom_table_read, i_rom_valid, i_stk_push, i_stk_pop;
    logic        o_rom_re, o_ram_we, o_ram_re, o_acc_we, o_pc_restore_valid, o_global_irq_enable, o_busy;
    logic [1:0]  i_mv_mode, dly;
    logic [7:0]  i_mv_addr, i_mv_literal, i_accumulator, i_ram_rdata, o_ram_wdata, o_accumulator;
    logic [7:0]  got, a, b, l, v, we_n;
    logic [15:0] i_rom_data, o_rom_addr, o_ram_addr, w;
    logic [23:0] wa;
    logic [9:0]  i_program_counter, o_pc_restore, p;
    logic [9:0]  pcs [5];
    int          fail_count, checks_done;

    pst_core_regs u_pst_core_regs (
        .i_sys_clk, .i_rst, .i_mv_valid, .i_mv_mode, .i_mv_to_acc, .i_mv_addr, .i_mv_literal, .i_accumulator,
        .i_rom_table_read, .i_rom_data, .i_rom_valid, .o_rom_addr, .o_rom_re, .i_ram_rdata, .o_ram_addr,
        .o_ram_wdata, .o_ram_we, .o_ram_re, .o_accumulator, .o_acc_we, .i_stk_push, .i_stk_pop,
        .i_program_counter, .o_pc_restore, .o_pc_restore_valid, .o_global_irq_enable, .o_busy
    );
    pst_mem_model u_pst_mem_model (
        .i_sys_clk, .i_rst, .i_ram_addr(o_ram_addr), .i_ram_re(o_ram_re), .i_rom_addr(o_rom_addr),
        .i_rom_re(o_rom_re), .i_delay(dly), .o_ram_rdata(i_ram_rdata), .o_rom_data(i_rom_data),
        .o_rom_valid(i_rom_valid)
    );

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // Wide enough for the address and data of a RAM store together
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One move or table read, called at a falling edge; waits out busy
    task automatic op(input logic rt, input logic [1:0] m, input logic ta, input logic [7:0] ad, input logic [7:0] d);
        got = 8'hxx;
        we_n = 8'h00;
        i_mv_valid = !rt;
        i_rom_table_read = rt;
        i_mv_mode = m;
        i_mv_to_acc = ta;
        i_mv_addr = ad;
        i_mv_literal = d;
        i_accumulator = d;
        for (int k = 0; k < 12; k++) begin
            @(negedge i_sys_clk);
            if (k == 0) begin
                i_mv_valid = 1'b0;
                i_rom_table_read = 1'b0;
            end
            if (o_ram_we === 1'b1) begin
                we_n++;
                wa = {o_ram_addr, o_ram_wdata};
            end
            if (o_acc_we === 1'b1) got = o_accumulator;
            if (k > 0 && o_busy === 1'b0) break;
        end
    endtask

    // Stack request levels held for one cycle; idle is stk(0,0,0)
    task automatic stk(input logic ps, input logic pp, input logic [9:0] pc);
        i_stk_push = ps;
        i_stk_pop = pp;
        i_program_counter = pc;
        @(negedge i_sys_clk);
    endtask

    task automatic final_report;
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_sys_clk);
        fail_count++;
        final_report();
    end

    initial begin
        {i_mv_valid, i_mv_to_acc, i_rom_table_read, i_stk_push, i_stk_pop, i_mv_mode, dly} = '0;
        {i_mv_addr, i_mv_literal, i_accumulator, i_program_counter} = '0;
        fail_count = 0;
        checks_done = 0;
        i_rst = 1'b1;
        void'($urandom(32'h1b4189f2));
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'b0;
        check(o_global_irq_enable, 1'b0);
        op(0, PST_MODE_DIR, 1, PST_OFS_STK_PTR, 0); check(got, 8'h03);
        op(0, PST_MODE_DIR, 0, PST_OFS_STK_PTR, 8'h03);
        for (int n = 0; n < 3; n++) begin
            v = 8'($urandom);
            a = PST_OFS_TBL_HIGH + 8'(n);
            op(0, PST_MODE_IMM, 0, a, v);
            op(0, PST_MODE_DIR, 1, a, 0); check(got, v);
        end
        v = 8'($urandom);
        op(0, PST_MODE_IMM, 1, 8'h40, v); check(got, v);
        foreach (pcs[n]) begin
            a = (n == 0) ? 8'h7f : (n == 1) ? 8'h80 : (n == 2) ? 8'h87 : 8'h88;
            op(0, PST_MODE_IMM, 0, a, v); check(we_n, (n == 1 || n == 2) ? 1 : 0);
        end
        a = 8'h10 + 8'($urandom % 8'h70);
        op(0, PST_MODE_DIR, 0, a, v); check(wa, {8'h00, a, v});
        op(0, PST_MODE_DIR, 1, a, 0); check(got, u_pst_mem_model.ram_fn({8'h00, a}));
        op(0, PST_MODE_IMM, 0, PST_OFS_BANK, 8'h00);
        op(0, PST_MODE_IMM, 0, PST_OFS_LOC, PST_OFS_LOC);
        op(0, PST_MODE_IND, 1, 0, 0); check(got, PST_OFS_LOC);
        repeat (4) begin
            b = 8'($urandom % 255 + 1);
            l = 8'($urandom);
            v = 8'($urandom);
            dly = 2'($urandom);
            op(0, PST_MODE_IMM, 0, PST_OFS_BANK, b);
            op(0, PST_MODE_IMM, 0, PST_OFS_LOC, l);
            op(0, PST_MODE_IND, 1, 0, 0); check(got, u_pst_mem_model.ram_fn({b, l}));
            op(0, PST_MODE_IND, 0, 0, v); check(wa, {b, l, v});
            w = u_pst_mem_model.rom_fn({b, l});
            op(1, PST_MODE_IMM, 0, 0, 0); check(o_rom_addr, {b, l});
            check(got, w[7:0]);
            op(0, PST_MODE_DIR, 1, PST_OFS_TBL_HIGH, 0); check(got, w[15:8]);
        end
        // Five calls: the fifth wraps over the oldest entry
        for (int n = 0; n < 5; n++) begin
            pcs[n] = 10'($urandom);
            stk(1, 0, pcs[n]);
            stk(0, 0, 0);
            op(0, PST_MODE_DIR, 1, PST_OFS_STK_PTR, 0); check(got, {6'h00, 2'h2 - 2'(n)});
            if (n < 4) begin
                op(0, PST_MODE_DIR, 1, PST_OFS_STK_FIRST + 8'(2 * n), 0); check(got, pcs[n][7:0]);
                op(0, PST_MODE_DIR, 1, PST_OFS_STK_FIRST + 8'(2 * n + 1), 0); check(got, pcs[n][9:8]);
            end
        end
        for (int n = 4; n > 0; n--) begin
            stk(0, 1, 0);
            check(o_pc_restore_valid, 1'b1);
            check(o_pc_restore, pcs[n]);
            stk(0, 0, 0);
        end
        p = 10'($urandom);
        stk(1, 0, p);
        stk(0, 1, 0);
        check(o_pc_restore, p);
        stk(0, 0, 0);
        // Software fills the top entry; mode code 3 acts as direct
        v = 8'($urandom);
        op(0, 2'h3, 0, PST_OFS_STK_FIRST, v);
        op(0, 2'h3, 0, PST_OFS_STK_FIRST + 8'h01, 8'h02);
        stk(0, 1, 0);
        check(o_pc_restore, {2'h2, v});
        stk(0, 0, 0);
        // Push outranks a pop in the same cycle
        stk(1, 1, p);
        check(o_pc_restore_valid, 1'b0);
        stk(0, 1, 0);
        check(o_pc_restore, p);
        stk(0, 0, 0);
        op(0, PST_MODE_DIR, 0, PST_OFS_STK_PTR, 8'h83); check(o_global_irq_enable, 1'b1);
        op(0, PST_MODE_DIR, 1, PST_OFS_STK_PTR, 0); check(got, 8'h83);
        i_rst = 1'b1;
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        check(o_global_irq_enable, 1'b0);
        op(0, PST_MODE_DIR, 1, PST_OFS_STK_PTR, 0); check(got, 8'h03);
        final_report();
    end
endmodule
